// File: ascf_axis_flags.sv
`timescale 1ns/10ps
`default_nettype none
module ascf_axis_flags
   import ascf_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   // External pins (asynchronous)
   input  wire logic [ASCF_AXES-1:0]   lower_limit_input,
   input  wire logic [ASCF_AXES-1:0]   stop_input,
   input  wire logic [ASCF_AXES-1:0]   dog_input,
   input  wire logic [ASCF_AXES-1:0]   change_input,
   // Configuration
   input  wire logic [ASCF_AXES-1:0]   use_signal_module,
   input  wire logic [ASCF_AXES-1:0]   dog_normally_closed,
   input  wire logic [ASCF_AXES-1:0]   abs_axis,
   input  wire logic [ASCF_AXES-1:0]   amp_fitted,
   input  wire logic [ASCF_AXES-1:0]   params_set,
   input  wire logic [ASCF_AXES-1:0]   clutch_output_ok,
   input  wire logic [ASCF_AXES-1:0]   cam_output,
   input  wire logic [ASCF_AXES-1:0]   abs_encoder_drive,
   // Amplifier and motion state
   input  wire logic [ASCF_AXES-1:0]   amp_ready,
   input  wire logic [ASCF_AXES-1:0]   amp_servo_error,
   input  wire logic [ASCF_AXES-1:0]   amp_power_on,
   input  wire logic [ASCF_AXES-1:0]   amp_torque_limit,
   input  wire logic [ASCF_AXES-1:0]   amp_dog,
   input  wire logic [ASCF_CODE_W-1:0] amp_error_code,
   input  wire logic [ASCF_AXES-1:0]   homing,
   input  wire logic [ASCF_AXES-1:0]   speed_pos_switching,
   input  wire logic [ASCF_AXES-1:0]   positioning,
   input  wire logic [ASCF_AXES-1:0]   clutch_engaged,
   input  wire logic                   virtual_mode,
   input  wire logic                   all_servo_on,
   input  wire logic                   forced_stop,
   input  wire logic [ASCF_AXES-1:0]   major_error_event,
   input  wire logic [ASCF_CODE_W-1:0] major_error_code,
   // Real-to-virtual switch data
   input  wire logic                   switch_req,
   input  wire logic [ASCF_POS_W-1:0]  feed_value,
   input  wire logic [ASCF_POS_W-1:0]  last_virtual_cmd,
   input  wire logic [ASCF_POS_W-1:0]  servo_position,
   input  wire logic [ASCF_POS_W-1:0]  in_pos_range,
   input  wire logic [ASCF_POS_W-1:0]  encoder_rev_value,
   input  wire logic [ASCF_POS_W-1:0]  stroke_ratio,
   input  wire logic                   cam_wr,
   input  wire logic [ASCF_CAM_AW-1:0] cam_wr_addr,
   input  wire logic [ASCF_POS_W-1:0]  cam_wr_data,
   // User commands
   input  wire logic [ASCF_AXES-1:0]   error_reset_cmd,
   input  wire logic [ASCF_AXES-1:0]   servo_error_reset_cmd,
   input  wire logic [ASCF_AXES-1:0]   clutch_ref_cmd,
   input  wire logic [ASCF_AXES-1:0]   cam_ref_cmd,
   input  wire logic [ASCF_AXES-1:0]   servo_off_cmd,
   input  wire logic [ASCF_AXES-1:0]   gain_change_cmd,
   // Status outputs
   output logic [ASCF_AXES-1:0]        lower_limit_status,
   output logic [ASCF_AXES-1:0]        stop_status,
   output logic [ASCF_AXES-1:0]        dog_change_status,
   output logic [ASCF_AXES-1:0]        servo_ready_status,
   output logic [ASCF_AXES-1:0]        torque_limit_status,
   output logic [ASCF_AXES-1:0]        error_detect_status,
   output logic [ASCF_AXES-1:0]        servo_error_status,
   output logic [ASCF_AXES*ASCF_CODE_W-1:0] minor_code,
   output logic [ASCF_AXES*ASCF_CODE_W-1:0] major_code,
   output logic [ASCF_AXES*ASCF_CODE_W-1:0] servo_code,
   output logic [ASCF_AXES*ASCF_DEV_W-1:0]  status_dev_no,
   output logic [ASCF_AXES*ASCF_DEV_W-1:0]  command_dev_no,
   // Amplifier controls and switch results
   output logic [ASCF_AXES-1:0]        amp_servo_on,
   output logic [ASCF_AXES-1:0]        amp_gain_alt,
   output logic [ASCF_AXES*ASCF_POS_W-1:0]  rev_value,
   output logic [ASCF_AXES*ASCF_POS_W-1:0]  lower_stroke,
   output logic                        switch_busy
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef logic [ASCF_AXES-1:0] ascf_vec_t;
   typedef struct packed {
      ascf_vec_t [3:0]            pin_m;
      ascf_vec_t [3:0]            pin_s;
      ascf_vec_t                  lls, sts, dcs, srd, tls, eds, ses;
      ascf_vec_t                  son, gain, pwr_q, off_lat;
      logic [ASCF_AXES-1:0][ASCF_CODE_W-1:0] mnr, mjr, svc;
      logic [ASCF_AXES-1:0][ASCF_POS_W-1:0]  rev, lsl, bdp;
      ascf_sw_t                   sw;
      logic [$clog2(ASCF_AXES)-1:0] ax;
      logic [ASCF_CAM_AW-1:0]     ptr;
   } ascf_state_t;

   ascf_state_t s_q, s_d;
   logic [ASCF_POS_W-1:0] cam_tbl_q [ASCF_CAM_PTS];
   logic                  rst_int_n;
   logic                  rst_m_q;
   logic                  rst_s_q;

   // Absolute difference of two positions
   function automatic logic [ASCF_POS_W-1:0] absdiff(input logic [ASCF_POS_W-1:0] a,
                                                     input logic [ASCF_POS_W-1:0] b);
      absdiff = (a >= b) ? a - b : b - a;
   endfunction

   // ------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end
   assign rst_int_n = rst_s_q;

   // Cam table, battery-backed in the real part so never reset
   always_ff @(posedge clk_sys) begin
      if (cam_wr) begin
         cam_tbl_q[cam_wr_addr] <= cam_wr_data;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [ASCF_AXES-1:0] dog_raw;
      logic                 cr_ok;
      int                   i;
      dog_raw = '0;
      cr_ok   = 1'b0;
      i       = 0;
      s_d = s_q;
      s_d.pin_m = {change_input, dog_input, stop_input, lower_limit_input};
      s_d.pin_s = s_q.pin_m;
      s_d.lls = ~s_q.pin_s[0];                                // RL1
      s_d.sts = s_q.pin_s[1];                                 // RL2
      // Dog from signal module or amplifier, polarity per setting
      for (i = 0; i < ASCF_AXES; i++) begin
         dog_raw[i] = use_signal_module[i] ? (s_q.pin_s[2][i] ^ dog_normally_closed[i])
                                           : amp_dog[i];       // RL3 RL5
         if (!virtual_mode && homing[i]) begin
            s_d.dcs[i] = dog_raw[i];                          // RL3
         end else if (!virtual_mode && speed_pos_switching[i] && use_signal_module[i]) begin
            s_d.dcs[i] = s_q.pin_s[3][i] ^ dog_normally_closed[i]; // RL4 RL5
         end
         // Servo-off latches only outside positioning and virtual-mode clutch-engaged
         if (!positioning[i] && !(servo_off_cmd[i] && virtual_mode && clutch_engaged[i])) begin
            s_d.off_lat[i] = servo_off_cmd[i];                // RL20 RL21
         end
         // Per-axis servo-on, errors only hit their own axis
         s_d.son[i] = all_servo_on && amp_fitted[i] && params_set[i] && !forced_stop
                      && !s_d.off_lat[i] && !s_q.ses[i];      // RL7 RL8
         s_d.srd[i] = s_d.son[i] && amp_ready[i];             // RL6 RL7
         s_d.tls[i] = amp_torque_limit[i];                    // RL9
         s_d.gain[i] = gain_change_cmd[i];                    // RL24
         s_d.pwr_q[i] = amp_power_on[i];
         // Resets first so that a same-cycle event still sets
         if (error_reset_cmd[i]) begin
            s_d.mnr[i] = ASCF_CODE_NONE;                      // RL11
            s_d.mjr[i] = ASCF_CODE_NONE;
            s_d.eds[i] = 1'b0;
         end
         if (servo_error_reset_cmd[i]) begin
            s_d.svc[i] = ASCF_CODE_NONE;                      // RL12
            s_d.ses[i] = 1'b0;
         end
         if (abs_axis[i] && amp_power_on[i] && !s_q.pwr_q[i]) begin
            s_d.mnr[i] = virtual_mode ? ASCF_ERR_PWR_VIRT : ASCF_ERR_PWR_REAL; // RL10
            s_d.eds[i] = 1'b1;
         end
         if (major_error_event[i]) begin
            s_d.mjr[i] = major_error_code;
            s_d.eds[i] = 1'b1;
         end
         if (amp_servo_error[i]) begin
            s_d.svc[i] = amp_error_code;
            s_d.ses[i] = 1'b1;
         end
         if (!positioning[i] && servo_off_cmd[i] && virtual_mode && clutch_engaged[i]) begin
            s_d.mnr[i] = ASCF_ERR_SVOFF_CLUTCH;               // RL22
            s_d.eds[i] = 1'b1;
         end
      end
      // Real-to-virtual switch walks the axes one at a time
      case (s_q.sw)
         ASCF_IDLE: begin
            if (switch_req) begin
               s_d.sw  = ASCF_SEARCH;
               s_d.ax  = '0;
               s_d.ptr = '0;
            end
         end
         ASCF_SEARCH: begin
            cr_ok = clutch_output_ok[s_q.ax];                 // RL13
            if (s_q.ptr == '0) begin
               if (cr_ok && clutch_ref_cmd[s_q.ax]) begin
                  s_d.rev[s_q.ax] = '0;                       // RL14
               end else if (cr_ok && abs_encoder_drive[s_q.ax]) begin
                  s_d.rev[s_q.ax] = encoder_rev_value;        // RL15
               end
            end
            if (!cam_output[s_q.ax]) begin
               s_d.sw = ASCF_DONE;
            end else if (cam_ref_cmd[s_q.ax]) begin
               s_d.lsl[s_q.ax] = feed_value;                  // RL16
               s_d.bdp[s_q.ax] = feed_value;                  // RL17
               s_d.rev[s_q.ax] = '0;
               s_d.sw = ASCF_DONE;
            end else if (absdiff(last_virtual_cmd, servo_position) <= in_pos_range) begin
               s_d.sw = ASCF_DONE;                            // RL18
            end else if (cam_tbl_q[s_q.ptr] == stroke_ratio) begin
               s_d.lsl[s_q.ax] = s_q.bdp[s_q.ax];             // RL19
               s_d.rev[s_q.ax] = ASCF_POS_W'(s_q.ptr);
               s_d.sw = ASCF_DONE;
            end else if (s_q.ptr == ASCF_CAM_AW'(ASCF_CAM_PTS - 1)) begin
               s_d.sw = ASCF_FAIL;
            end else begin
               s_d.ptr = s_q.ptr + 1'b1;                      // RL19
            end
         end
         ASCF_DONE, ASCF_FAIL: begin
            s_d.ptr = '0;
            if (s_q.ax == $clog2(ASCF_AXES)'(ASCF_AXES - 1)) begin
               s_d.sw = ASCF_IDLE;
            end else begin
               s_d.ax = s_q.ax + 1'b1;
               s_d.sw = ASCF_SEARCH;
            end
         end
         default: s_d.sw = ASCF_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // State register, reset taken from the two release flops
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         {s_q.pin_m, s_q.pin_s, s_q.lls, s_q.sts, s_q.dcs, s_q.srd, s_q.tls,
          s_q.eds, s_q.ses, s_q.son, s_q.gain, s_q.pwr_q, s_q.off_lat,
          s_q.mnr, s_q.mjr, s_q.svc, s_q.rev, s_q.lsl, s_q.bdp} <= '0;
         s_q.sw  <= ASCF_IDLE;
         s_q.ax  <= '0;
         s_q.ptr <= '0;
      end else begin
         {s_q.pin_m, s_q.pin_s, s_q.lls, s_q.sts, s_q.dcs, s_q.srd, s_q.tls,
          s_q.eds, s_q.ses, s_q.son, s_q.gain, s_q.pwr_q, s_q.off_lat,
          s_q.mnr, s_q.mjr, s_q.svc, s_q.rev, s_q.lsl, s_q.bdp} <=
         {s_d.pin_m, s_d.pin_s, s_d.lls, s_d.sts, s_d.dcs, s_d.srd, s_d.tls,
          s_d.eds, s_d.ses, s_d.son, s_d.gain, s_d.pwr_q, s_d.off_lat,
          s_d.mnr, s_d.mjr, s_d.svc, s_d.rev, s_d.lsl, s_d.bdp};
         s_q.sw  <= s_d.sw;
         s_q.ax  <= s_d.ax;
         s_q.ptr <= s_d.ptr;
      end
   end

   // ------------------------------------------------------------
   // Outputs and per-axis device numbers
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < ASCF_AXES; g++) begin : g_ax
         assign status_dev_no[g*ASCF_DEV_W +: ASCF_DEV_W]  = ASCF_STAT_BASE + ASCF_STRIDE * 16'(g); // RL23
         assign command_dev_no[g*ASCF_DEV_W +: ASCF_DEV_W] = ASCF_CMD_BASE + ASCF_STRIDE * 16'(g);  // RL23
      end
   endgenerate
   assign lower_limit_status  = s_q.lls;
   assign stop_status         = s_q.sts;
   assign dog_change_status   = s_q.dcs;
   assign servo_ready_status  = s_q.srd;
   assign torque_limit_status = s_q.tls;
   assign error_detect_status = s_q.eds;
   assign servo_error_status  = s_q.ses;
   assign minor_code          = s_q.mnr;
   assign major_code          = s_q.mjr;
   assign servo_code          = s_q.svc;
   assign amp_servo_on        = s_q.son;
   assign amp_gain_alt        = s_q.gain;
   assign rev_value           = s_q.rev;
   assign lower_stroke        = s_q.lsl;
   assign switch_busy         = (s_q.sw != ASCF_IDLE);
endmodule
`default_nettype wire

// File: ascf_pkg.sv
// How it works
// RL1: Lower limit status is inverted limit input
// RL2: Stop status follows stop input directly
// RL3: Homing: dog status follows proximity dog
// RL4: Speed/position switching: status follows switch input
// RL5: Contact polarity selectable for signal-module input
// RL6: Servo ready set when amplifier reports ready
// RL7: Servo ready cleared by any blocking condition
// RL8: Servo error affects only its own axis
// RL9: Torque limit status mirrors torque limiting
// RL10: Absolute amplifier power-on raises code 901/9010
// RL11: Error reset clears minor/major codes and flag
// RL12: Servo error reset clears code and flag
// RL13: Clutch reference only for address clutch/rotary
// RL14: Clutch reference on: revolution value zero
// RL15: Clutch reference off: resume or recompute value
// RL16: Cam reference on: feed is bottom, zero
// RL17: Bottom dead point kept in backed memory (here bdp sits in the state register and is cleared by reset)
// RL18: Gap within range: reuse stroke and revolution
// RL19: Gap exceeds range: search cam table ratio
// RL20: Servo-off command low servo on, high free-run
// RL21: Servo-off ignored while axis is positioning
// RL22: Virtual clutch engaged: servo-off rejected, minor error
// RL23: Axis bits at base plus twenty times index
// RL24: Gain command forwarded to amplifier gain select
package ascf_pkg;
   // ------------------------------------------------------------
   // Sizes and codes
   // ------------------------------------------------------------
   localparam int          ASCF_AXES      = 8;
   localparam int          ASCF_CODE_W    = 16;
   localparam int          ASCF_POS_W     = 32;
   localparam int          ASCF_CAM_PTS   = 16;
   localparam int          ASCF_CAM_AW    = 4;
   localparam int          ASCF_DEV_W     = 16;
   localparam logic [15:0] ASCF_ERR_PWR_REAL = 16'h0385; // 901
   localparam logic [15:0] ASCF_ERR_PWR_VIRT = 16'h2332; // 9010
   localparam logic [15:0] ASCF_ERR_SVOFF_CLUTCH = 16'h0001; // Chosen code
   localparam logic [15:0] ASCF_STRIDE    = 16'h0014; // Twenty bits per axis
   localparam logic [15:0] ASCF_STAT_BASE = 16'h0960; // Status base number
   localparam logic [15:0] ASCF_CMD_BASE  = 16'h0c80; // Command base number
   localparam logic [ASCF_CODE_W-1:0] ASCF_CODE_NONE = '0;
   typedef enum logic [3:0] {
      ASCF_IDLE   = 4'b0001,
      ASCF_SEARCH = 4'b0010,
      ASCF_DONE   = 4'b0100,
      ASCF_FAIL   = 4'b1000
   } ascf_sw_t;
endpackage

// File: ascf_axis_flags_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ascf_axis_flags_properties
   import ascf_pkg::*;
(
   // Clock and reset
   input wire logic                           clk_sys,
   input wire logic                           rst_n,
   // Watched inputs
   input wire logic [ASCF_AXES-1:0]           lower_limit_input, stop_input, amp_torque_limit,
   input wire logic [ASCF_AXES-1:0]           gain_change_cmd, amp_ready, servo_off_cmd,
   input wire logic [ASCF_AXES-1:0]           positioning, error_reset_cmd, amp_servo_error,
   input wire logic [ASCF_AXES-1:0]           servo_error_reset_cmd, major_error_event,
   input wire logic [ASCF_AXES-1:0]           amp_power_on,
   input wire logic                           all_servo_on, forced_stop, virtual_mode,
   // Watched outputs
   input wire logic [ASCF_AXES-1:0]           lower_limit_status, stop_status, amp_servo_on,
   input wire logic [ASCF_AXES-1:0]           torque_limit_status, amp_gain_alt,
   input wire logic [ASCF_AXES-1:0]           servo_ready_status, error_detect_status,
   input wire logic [ASCF_AXES-1:0]           servo_error_status,
   input wire logic [ASCF_AXES*ASCF_CODE_W-1:0] minor_code, servo_code
);
   // ----------------------------------------
   // Settling counter
   // ----------------------------------------
   // The internal reset copy lags rst_n, so checks wait out the first edges
   logic [2:0] up_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_lim_inverted: assert property (
      up_q == 3'h7 |-> lower_limit_status == ~$past(lower_limit_input, 3))
      else $error("lower limit status wrong");
   a_stop_follow: assert property (
      up_q == 3'h7 |-> stop_status == $past(stop_input, 3))
      else $error("stop status wrong");
   a_torque_mirror: assert property (
      up_q == 3'h7 |-> torque_limit_status == $past(amp_torque_limit))
      else $error("torque status wrong");
   a_gain_fwd: assert property (
      up_q == 3'h7 |-> amp_gain_alt == $past(gain_change_cmd))
      else $error("gain select wrong");
   a_ready_blocked: assert property (
      up_q == 3'h7 && (!all_servo_on || forced_stop) |=> servo_ready_status == '0)
      else $error("ready while blocked");
   a_ready_cause: assert property (
      up_q == 3'h7 |-> (servo_ready_status & ~$past(amp_ready)) == '0)
      else $error("ready without drive ready");
   a_svoff_free: assert property (
      up_q == 3'h7 && servo_off_cmd[2] && !positioning[2] && !virtual_mode
      |=> !amp_servo_on[2])
      else $error("servo off not obeyed");
   a_err_clear: assert property (
      up_q == 3'h7 && error_reset_cmd[0] && !major_error_event[0] && !virtual_mode
      && $stable(amp_power_on[0]) && amp_power_on[0] == $past(amp_power_on[0], 2)
      |=> !error_detect_status[0] && minor_code[15:0] == '0)
      else $error("error reset ignored");
   a_svoerr_clear: assert property (
      up_q == 3'h7 && servo_error_reset_cmd[1] && !amp_servo_error[1]
      |=> !servo_error_status[1] && servo_code[31:16] == '0)
      else $error("servo error reset ignored");
endmodule
`default_nettype wire

// File: ascf_amp_model.sv
`timescale 1ns/10ps
`default_nettype none
module ascf_amp_model
   import ascf_pkg::*;
#(
   parameter int          READY_DLY = 4,
   parameter logic [15:0] ERR_CODE  = 16'h0123
)
(
   // Clock
   input wire logic                   clk_sys,
   // Bench controls
   input wire logic [ASCF_AXES-1:0]   amp_power_on, fault_req, torque_req,
   // Drive view seen by the block
   output logic [ASCF_AXES-1:0]       amp_ready, amp_servo_error, amp_torque_limit,
   output logic [ASCF_CODE_W-1:0]     amp_error_code
);
   // ----------------------------------------
   // Boot delay
   // ----------------------------------------
   // A drive reports ready only some cycles after power, never at once
   int up_cnt [ASCF_AXES];
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < ASCF_AXES; i++) begin
         up_cnt[i] <= amp_power_on[i] ? up_cnt[i] + 1 : 0;
         amp_ready[i] <= amp_power_on[i] && up_cnt[i] >= READY_DLY;
      end
   end
   // Faults and clamping exist only while powered; code is junk without a fault
   assign amp_servo_error  = fault_req & amp_power_on;
   assign amp_torque_limit = torque_req & amp_power_on;
   assign amp_error_code   = (amp_servo_error != '0) ? ERR_CODE : ~ERR_CODE;
endmodule
`default_nettype wire

// File: ascf_axis_flags_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ascf_axis_flags_tb_top
   import ascf_pkg::*;
();
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   typedef logic [ASCF_AXES-1:0] ascf_b_t;
   logic    clk_sys, rst_n, virtual_mode, all_servo_on, forced_stop, switch_req, cam_wr;
   ascf_b_t lower_limit_input, stop_input, dog_input, change_input, use_signal_module;
   ascf_b_t dog_normally_closed, abs_axis, amp_fitted, params_set, clutch_output_ok, cam_output;
   ascf_b_t abs_encoder_drive, amp_ready, amp_servo_error, amp_power_on, amp_torque_limit;
   ascf_b_t amp_dog, homing, speed_pos_switching, positioning, clutch_engaged, major_error_event;
   ascf_b_t error_reset_cmd, servo_error_reset_cmd, clutch_ref_cmd, cam_ref_cmd, servo_off_cmd;
   ascf_b_t gain_change_cmd, fault_req, torque_req, lower_limit_status, stop_status;
   ascf_b_t dog_change_status, servo_ready_status, torque_limit_status, error_detect_status;
   ascf_b_t servo_error_status, amp_servo_on, amp_gain_alt;
   logic [15:0]  amp_error_code, major_error_code;
   logic [3:0]   cam_wr_addr;
   logic [31:0]  feed_value, last_virtual_cmd, servo_position, in_pos_range, encoder_rev_value;
   logic [31:0]  stroke_ratio, cam_wr_data, r;
   logic [127:0] minor_code, major_code, servo_code, status_dev_no, command_dev_no;
   logic [255:0] rev_value, lower_stroke;
   logic         switch_busy;
   int           err_count, n_compared, cyc;
   logic [31:0]  q[$];
   ascf_axis_flags ascf_axis_flags_inst (.*);
   ascf_amp_model #(.READY_DLY(4), .ERR_CODE(16'h0123)) ascf_amp_model_inst (
      .clk_sys(clk_sys), .amp_power_on(amp_power_on), .fault_req(fault_req),
      .torque_req(torque_req), .amp_ready(amp_ready), .amp_servo_error(amp_servo_error),
      .amp_torque_limit(amp_torque_limit), .amp_error_code(amp_error_code));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Checks land 1 ns after the edge so the edge's updates have settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic do_switch();
      @(posedge clk_sys);
      switch_req <= 1'b1;
      @(posedge clk_sys);
      switch_req <= 1'b0;
      settle(1);
      for (int w = 0; w < 300 && switch_busy !== 1'b0; w++) settle(1);
      chk(switch_busy, 1'b0);
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Clock and hang guard; the run needs well under a thousand cycles
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {clk_sys, rst_n, virtual_mode, all_servo_on, forced_stop, switch_req, cam_wr,
       lower_limit_input, stop_input, dog_input, change_input, use_signal_module,
       dog_normally_closed, abs_axis, amp_fitted, params_set, clutch_output_ok, cam_output,
       abs_encoder_drive, amp_power_on, amp_dog, homing, speed_pos_switching, positioning,
       clutch_engaged, major_error_event, error_reset_cmd, servo_error_reset_cmd,
       clutch_ref_cmd, cam_ref_cmd, servo_off_cmd, gain_change_cmd, fault_req, torque_req,
       major_error_code, cam_wr_addr, feed_value, last_virtual_cmd, servo_position,
       in_pos_range, encoder_rev_value, stroke_ratio, cam_wr_data} = '0;
      void'($urandom(1));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      amp_fitted <= '1;
      params_set <= '1;
      amp_power_on <= '1;
      all_servo_on <= 1'b1;
      use_signal_module <= '1;
      // Random pin and command traffic checked against a history queue
      for (int k = 0; k < 200; k++) begin
         @(posedge clk_sys);
         r = $urandom;
         lower_limit_input <= r[7:0];
         stop_input <= r[15:8];
         torque_req <= r[23:16];
         gain_change_cmd <= r[31:24];
         #1;
         if (k > 3) begin
            chk(lower_limit_status, q[k-3][7:0] ^ 8'hff);
            chk(stop_status, q[k-3][15:8]);
            chk(torque_limit_status, q[k-1][23:16]);
            chk(amp_gain_alt, q[k-1][31:24]);
         end
         q.push_back(r);
      end
      for (int i = 0; i < ASCF_AXES; i++) begin
         chk(status_dev_no[16*i +: 16], 2400 + 20 * i);
         chk(command_dev_no[16*i +: 16], 3200 + 20 * i);
      end
      chk(servo_ready_status, 8'hff);
      @(posedge clk_sys);
      positioning <= 8'h08;
      servo_off_cmd <= 8'h0c;
      settle(3);
      chk(servo_ready_status, 8'hfb);
      @(posedge clk_sys);
      positioning <= '0;
      servo_off_cmd <= '0;
      // All-servo-on, forced stop, amp fitted and params set in turn, last pass with all of them lifted
      for (int c = 0; c < 5; c++) begin
         @(posedge clk_sys);
         all_servo_on <= (c != 0);
         forced_stop <= (c == 1);
         amp_fitted <= (c == 2) ? 8'hfe : 8'hff;
         params_set <= (c == 3) ? 8'h7f : 8'hff;
         settle(3);
         chk(servo_ready_status, c < 2 ? 8'h00 : c == 2 ? 8'hfe : c == 3 ? 8'h7f : 8'hff);
      end
      @(posedge clk_sys);
      fault_req <= 8'h02;
      settle(3);
      chk(servo_ready_status, 8'hfd);
      chk(servo_error_status, 8'h02);
      chk(servo_code[31:16], 16'h0123);
      @(posedge clk_sys);
      fault_req <= '0;
      servo_error_reset_cmd <= 8'h02;
      settle(3);
      chk(servo_error_status, 8'h00);
      chk(servo_code[31:16], 16'h0000);
      @(posedge clk_sys);
      servo_error_reset_cmd <= '0;
      abs_axis <= 8'h11;
      amp_power_on <= 8'hee;
      @(posedge clk_sys);
      amp_power_on <= 8'hef;
      @(posedge clk_sys);
      virtual_mode <= 1'b1;
      @(posedge clk_sys);
      amp_power_on <= 8'hff;
      clutch_engaged <= 8'h20;
      servo_off_cmd <= 8'h20;
      major_error_event <= 8'h04;
      major_error_code <= r[15:0];
      @(posedge clk_sys);
      major_error_event <= '0;
      settle(3);
      chk(minor_code[15:0], 16'd901);
      chk(minor_code[79:64], 16'd9010);
      chk(minor_code[95:80], 16'h0001);
      chk(amp_servo_on, 8'hff);
      chk(major_code[47:32], r[15:0]);
      chk(error_detect_status, 8'h35);
      @(posedge clk_sys);
      virtual_mode <= 1'b0;
      clutch_engaged <= '0;
      servo_off_cmd <= '0;
      error_reset_cmd <= 8'h35;
      settle(3);
      chk(error_detect_status, 8'h00);
      chk(minor_code[95:64] | minor_code[31:0] | major_code[47:32], 32'h0);
      @(posedge clk_sys);
      error_reset_cmd <= '0;
      homing <= 8'h01;
      speed_pos_switching <= 8'h02;
      dog_input <= 8'h01;
      change_input <= 8'h02;
      settle(4);
      chk(dog_change_status & 8'h03, 8'h03);
      @(posedge clk_sys);
      dog_normally_closed <= 8'h03;
      settle(4);
      chk(dog_change_status & 8'h03, 8'h00);
      @(posedge clk_sys);
      use_signal_module <= '0;
      amp_dog <= 8'h01;
      settle(4);
      chk(dog_change_status & 8'h03, 8'h01);
      @(posedge clk_sys);
      use_signal_module <= '1;
      cam_output <= '1;
      clutch_output_ok <= '1;
      cam_ref_cmd <= '1;
      clutch_ref_cmd <= '1;
      feed_value <= r;
      stroke_ratio <= ~r;
      do_switch();
      for (int i = 0; i < ASCF_AXES; i++) begin
         chk(lower_stroke[32*i +: 32], r);
         chk(rev_value[32*i +: 32], 32'h0);
      end
      // Gap exactly at the in-position limit keeps the earlier values
      @(posedge clk_sys);
      cam_ref_cmd <= '0;
      clutch_ref_cmd <= '0;
      feed_value <= ~r;
      last_virtual_cmd <= r;
      servo_position <= r - 32'd5;
      in_pos_range <= 32'd5;
      do_switch();
      chk(lower_stroke[31:0], r);
      chk(rev_value[31:0], 32'h0);
      @(posedge clk_sys);
      {cam_wr, cam_wr_addr, cam_wr_data, servo_position} <= {1'b1, 4'h3, ~r, r - 32'd6};
      @(posedge clk_sys);
      cam_wr <= 1'b0;
      do_switch();
      chk(lower_stroke[31:0], r);
      chk(rev_value[31:0], 32'h3);
      report_and_stop();
   end
endmodule
bind ascf_axis_flags ascf_axis_flags_properties ascf_axis_flags_properties_inst (.*);
`default_nettype wire
